// ---- ict_channel.sv ----
// Data channel: unit selection, command load, word transfer and storage arbitration
`timescale 1ns/1ps
`default_nettype none
module ict_channel #(
  parameter logic [3:0] CHAN_NUM = 4'h1,
  parameter logic [11:0] START_OPCODE = 12'h001,
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Processor instruction stream
  input wire logic cpu_sel_valid,
  input wire logic cpu_sel_write,
  input wire ict_pkg::ict_sel_t cpu_sel_addr,
  input wire logic cpu_start_valid,
  input wire logic [11:0] cpu_start_opcode,
  input wire logic [14:0] cpu_start_addr,
  input wire logic cpu_io_test,
  output logic io_check,
  output logic chan_busy,
  output ict_pkg::ict_cmd_t stat_word,
  output logic [14:0] stat_loc,
  // Processor storage access
  input wire logic cpu_mem_req,
  output logic cpu_mem_gnt,
  output logic cpu_stall,
  // Other channels' storage requests, index 0 unused
  input wire logic [NCH-1:0] ext_chan_req,
  output logic [NCH-1:0] chan_gnt,
  // Core storage
  output logic mem_req,
  output logic mem_we,
  output logic [14:0] mem_addr,
  output logic [35:0] mem_wdata,
  input wire logic [35:0] mem_rdata,
  // Tape unit control
  output logic tape_sel,
  output logic tape_sel_write,
  output logic tape_sel_binary,
  output logic [3:0] tape_sel_unit,
  output logic tape_disc,
  input wire logic tape_eof,
  // Tape word streams
  input wire logic tape_rd_valid,
  input wire logic [35:0] tape_rd_data,
  output logic tape_rd_ready,
  output logic tape_wr_valid,
  output logic [35:0] tape_wr_data,
  input wire logic tape_wr_ready
);
  import ict_pkg::*;

  ict_state_t state_r, state_nxt;
  logic [14:0] count_r, addr_r, loc_r;
  logic [3:0] oper_r;
  logic [35:0] buf_r;
  logic buf_full_r, rd_pend_r, writing_r, binary_r, check_r;
  logic [3:0] unit_r;
  logic [WIN_W-1:0] win_r;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  // channel field match
  wire sel_chan_hit = cpu_sel_addr.chan == CHAN_NUM;
  wire sel_bcd = cpu_sel_addr.mode == UNIT_BCD;
  wire sel_bin = cpu_sel_addr.mode == UNIT_BIN;
  wire sel_unit_ok = cpu_sel_addr.unit != 4'h0 && cpu_sel_addr.unit <= MAX_UNITS;
  wire sel_hit = cpu_sel_valid && sel_chan_hit && (sel_bcd || sel_bin) && sel_unit_ok;
  wire start_hit = cpu_start_valid && cpu_start_opcode == START_OPCODE;
  wire connected = state_r != ST_IDLE;
  wire in_sel = state_r == ST_SEL;
  wire in_xfer = state_r == ST_XFER;
  wire win_over = in_sel && win_r == WIN_W'(WIN_CYC);
  ict_cmd_t cmd;
  assign cmd = mem_rdata;
  wire cmd_xfer = cmd.op == OP_TRANSFER;
  wire skip = ~writing_r && oper_r[0];
  wire cnt_zero = count_r == REG_RST;
  wire eof_hit = in_xfer && ~writing_r && tape_eof;
  wire own_req = (state_r == ST_FETCH && !rd_pend_r)
    || (in_xfer && !eof_hit && !cnt_zero && !skip && !rd_pend_r && (writing_r ? !buf_full_r : buf_full_r));
  wire skip_step = in_xfer && skip && buf_full_r && !cnt_zero && !eof_hit;
  wire wr_out = in_xfer && writing_r && tape_wr_ready && buf_full_r;

  ////////////////////////////////////////////////////////////////////////////
  // Storage arbitration
  // lowest index wins
  wire [NCH-1:0] chan_req = {ext_chan_req[NCH-1:1], own_req};
  assign chan_gnt = chan_req & (~chan_req + NCH'(1));
  wire any_chan = |chan_req;
  wire own_gnt = chan_gnt[0];
  // channels always ahead of the processor
  assign cpu_stall = cpu_mem_req && any_chan;
  assign cpu_mem_gnt = cpu_mem_req && !any_chan;
  assign mem_req = own_req;
  assign mem_we = in_xfer && !writing_r;
  assign mem_addr = in_xfer ? addr_r : loc_r;
  assign mem_wdata = buf_r;
  assign tape_wr_data = buf_r;
  assign tape_wr_valid = in_xfer && writing_r && buf_full_r;
  assign tape_rd_ready = in_xfer && !writing_r && !buf_full_r && !cnt_zero;
  wire rd_in = tape_rd_valid && tape_rd_ready;
  wire word_done = (own_gnt && in_xfer) || skip_step;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (sel_hit) state_nxt = ST_SEL;
      ST_SEL:
        if (start_hit) state_nxt = ST_FETCH;
        else if (win_over) state_nxt = ST_IDLE;
      ST_FETCH:
        if (own_gnt) state_nxt = ST_LOAD;
      ST_LOAD:
        state_nxt = cmd_xfer ? ST_FETCH : ST_XFER;
      ST_XFER:
        // end of file or count exhausted
        if (eof_hit || (cnt_zero && !buf_full_r && !rd_pend_r)) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !in_sel) win_r <= '0;
    else win_r <= win_r + WIN_W'(1);
  end

  // direction and mode latched at select
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      writing_r <= 1'b0;
      binary_r <= 1'b0;
      unit_r <= 4'h0;
    end
    else if (sel_hit && state_r == ST_IDLE)
    begin
      writing_r <= cpu_sel_write;
      binary_r <= sel_bin;
      unit_r <= cpu_sel_addr.unit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  // command pointer
  always_ff @(posedge clk)
  begin
    if (rst) loc_r <= REG_RST;
    else if (in_sel && start_hit) loc_r <= cpu_start_addr;
    else if (state_r == ST_LOAD && cmd_xfer) loc_r <= cmd.addr;
    else if (state_r == ST_FETCH && own_gnt) loc_r <= loc_r + 15'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r <= REG_RST;
      addr_r <= REG_RST;
      oper_r <= 4'h0;
    end
    else if (state_r == ST_LOAD && !cmd_xfer)
    begin
      count_r <= cmd.count;
      addr_r <= cmd.addr;
      oper_r <= {cmd.op, cmd.nontx};
    end
    else if (word_done)
    begin
      count_r <= count_r - 15'h0001;
      addr_r <= addr_r + 15'h0001;
    end
  end

  // Read data comes back one cycle after the grant
  always_ff @(posedge clk)
  begin
    if (rst) rd_pend_r <= 1'b0;
    else rd_pend_r <= own_gnt && !mem_we;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      buf_r <= '0;
      buf_full_r <= 1'b0;
    end
    else if (rd_pend_r && in_xfer)
    begin
      buf_r <= mem_rdata;
      buf_full_r <= 1'b1;
    end
    else if (rd_in)
    begin
      buf_r <= tape_rd_data;
      buf_full_r <= 1'b1;
    end
    else if (word_done || wr_out || !in_xfer) buf_full_r <= 1'b0;
  end

  // set wins over the test clear
  always_ff @(posedge clk)
  begin
    if (rst) check_r <= 1'b0;
    else if (start_hit && !in_sel) check_r <= 1'b1;
    else if (cpu_io_test) check_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign io_check = check_r;
  assign chan_busy = in_xfer || state_r == ST_FETCH || state_r == ST_LOAD;
  assign stat_word = '{op: oper_r[3:1], count: count_r, rsv18: 1'b0, nontx: oper_r[0],
    rsv20: 1'b0, addr: addr_r};
  assign stat_loc = loc_r;
  assign tape_sel = in_sel;
  assign tape_sel_write = writing_r;
  assign tape_sel_binary = binary_r;
  assign tape_sel_unit = unit_r;
  assign tape_disc = connected && state_nxt == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_cpu_waits;
    @(posedge clk) disable iff (rst) cpu_mem_req && any_chan |-> !cpu_mem_gnt && cpu_stall;
  endproperty
  a_cpu_waits: assert property (p_cpu_waits) else $error("processor granted over channel");

  property p_idle_grant;
    @(posedge clk) disable iff (rst) !cpu_mem_req && own_req && !(|ext_chan_req[NCH-1:1]) |-> own_gnt && !cpu_stall;
  endproperty
  a_idle_grant: assert property (p_idle_grant) else $error("idle storage not granted");

  property p_one_grant;
    @(posedge clk) disable iff (rst) $onehot0(chan_gnt) && (chan_gnt & ~chan_req) == '0 && (any_chan == (|chan_gnt));
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("bad channel grant");

  property p_count_step;
    @(posedge clk) disable iff (rst) word_done |=> count_r == $past(count_r) - 15'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count not decremented");

  property p_addr_step;
    @(posedge clk) disable iff (rst) word_done |=> addr_r == $past(addr_r) + 15'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not incremented");

  property p_loc_next;
    @(posedge clk) disable iff (rst) state_r == ST_FETCH && own_gnt |=> loc_r == $past(loc_r) + 15'h0001;
  endproperty
  a_loc_next: assert property (p_loc_next) else $error("location not advanced");

  property p_skip;
    @(posedge clk) disable iff (rst) in_xfer && skip |-> !mem_req;
  endproperty
  a_skip: assert property (p_skip) else $error("storage touched in skip mode");

  property p_late;
    @(posedge clk) disable iff (rst) win_over && !start_hit |=> state_r == ST_IDLE;
  endproperty
  a_late: assert property (p_late) else $error("late start not dropped");

  property p_check;
    @(posedge clk) disable iff (rst) start_hit && !in_sel |=> io_check;
  endproperty
  a_check: assert property (p_check) else $error("check not set");

  property p_eof;
    @(posedge clk) disable iff (rst) eof_hit |=> state_r == ST_IDLE && $stable(addr_r) && $stable(loc_r)
      && $stable(count_r);
  endproperty
  a_eof: assert property (p_eof) else $error("eof did not end command");

  property p_zero;
    @(posedge clk) disable iff (rst) in_xfer && cnt_zero |-> !mem_req ##1 !word_done;
  endproperty
  a_zero: assert property (p_zero) else $error("transfer past zero count");

  property p_rd_stop;
    @(posedge clk) disable iff (rst) in_xfer && cnt_zero |-> !tape_rd_ready;
  endproperty
  a_rd_stop: assert property (p_rd_stop) else $error("tape word taken at zero count");
endmodule : ict_channel
`default_nettype wire

// ---- ict_far_model.sv ----
// Storage and tape unit model for the channel bench
`timescale 1ns/1ps
`default_nettype none
module ict_far_model (
  // Clock
  input wire logic clk,
  // Storage
  input wire logic mem_go,
  input wire logic mem_we,
  input wire logic [14:0] mem_addr,
  input wire logic [35:0] mem_wdata,
  output logic [35:0] mem_rdata,
  // Tape
  output logic rd_valid,
  output logic [35:0] rd_data,
  input wire logic rd_ready,
  input wire logic wr_valid,
  input wire logic [35:0] wr_data,
  output logic wr_ready
);
  logic [35:0] mem [0:31];
  logic [35:0] last_wr = 36'h0;
  logic [35:0] rdq = 36'h0;
  int nwr = 0;
  int nrd = 0;
  assign wr_ready = 1'b1;
  assign rd_valid = 1'b1;
  assign mem_rdata = rdq;
  assign rd_data = {4'h9, 32'h5a5a0000 + 32'(nrd)};
  always @(posedge clk)
  begin
    // Data toggles when not answering, so stale words never look valid
    rdq <= ~rdq;
    if (mem_go && mem_we) mem[mem_addr[4:0]] <= mem_wdata;
    if (mem_go && !mem_we) rdq <= mem[mem_addr[4:0]];
    if (rd_ready) nrd <= nrd + 1;
    if (wr_valid)
    begin
      last_wr <= wr_data;
      nwr <= nwr + 1;
    end
  end
endmodule : ict_far_model
`default_nettype wire

// ---- ict_pkg.sv ----
// Package: constants and types of the channel transfer engine
package ict_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WIN_NS = 1000;
  localparam int WIN_CYC = (WIN_NS / CLK_PERIOD_NS < 1) ? 1 : WIN_NS / CLK_PERIOD_NS;
  localparam int WIN_W = $clog2(WIN_CYC + 1);
  localparam int WORD_W = 36;
  localparam int REG_W = 15;
  // Upper five bits of the nine-bit unit code; units 1 to 10 in the low four
  localparam logic [4:0] UNIT_BCD = 5'h08;
  localparam logic [4:0] UNIT_BIN = 5'h09;
  localparam logic [3:0] MAX_UNITS = 4'ha;
  localparam logic [2:0] OP_TRANSFER = 3'h7;
  localparam logic [14:0] REG_RST = 15'h0000;
  // Command word, bit S (the sign) first
  typedef struct packed {
    logic [2:0] op;
    logic [14:0] count;
    logic rsv18;
    logic nontx;
    logic rsv20;
    logic [14:0] addr;
  } ict_cmd_t;
  // Joint address of a unit-selection instruction
  typedef struct packed {
    logic [1:0] unused;
    logic [3:0] chan;
    logic [4:0] mode;
    logic [3:0] unit;
  } ict_sel_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEL = 5'h02,
    ST_FETCH = 5'h04,
    ST_LOAD = 5'h08,
    ST_XFER = 5'h10
  } ict_state_t;
endpackage : ict_pkg

// ---- test_io_channel_transfer_engine.sv ----
// Self-checking bench of the channel transfer engine
`timescale 1ns/1ps
`default_nettype none
module test_io_channel_transfer_engine;
  import ict_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cpu_sel_valid = 1'b0, cpu_sel_write = 1'b0, cpu_start_valid = 1'b0;
  logic cpu_io_test = 1'b0, cpu_mem_req = 1'b0, io_check, chan_busy, cpu_mem_gnt, cpu_stall, tape_eof = 1'b0;
  logic mem_req, mem_we, tape_sel, tape_sel_write, tape_sel_binary, tape_disc, tape_rd_valid;
  logic tape_rd_ready, tape_wr_valid, tape_wr_ready;
  ict_sel_t cpu_sel_addr = '0;
  logic [11:0] cpu_start_opcode = 12'h001;
  logic [14:0] cpu_start_addr = 15'h0000, stat_loc, mem_addr;
  ict_cmd_t stat_word;
  logic [7:0] chan_gnt, ext_chan_req = 8'h00;
  logic [35:0] mem_wdata, mem_rdata, tape_rd_data, tape_wr_data;
  logic [3:0] tape_sel_unit;
  int num_errors = 0, checked = 0, cyc = 0, ndisc = 0, b;
  always #2.5 clk = ~clk;
  ict_channel i_dut (.clk, .rst, .cpu_sel_valid, .cpu_sel_write, .cpu_sel_addr, .cpu_start_valid,
    .cpu_start_opcode, .cpu_start_addr, .cpu_io_test, .io_check, .chan_busy, .stat_word, .stat_loc,
    .cpu_mem_req, .cpu_mem_gnt, .cpu_stall, .ext_chan_req, .chan_gnt, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .tape_sel, .tape_sel_write, .tape_sel_binary, .tape_sel_unit,
    .tape_disc, .tape_eof, .tape_rd_valid, .tape_rd_data, .tape_rd_ready, .tape_wr_valid,
    .tape_wr_data, .tape_wr_ready);
  ict_far_model i_far (.clk, .mem_go(mem_req && chan_gnt[0]), .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .rd_valid(tape_rd_valid), .rd_data(tape_rd_data), .rd_ready(tape_rd_ready),
    .wr_valid(tape_wr_valid && tape_wr_ready), .wr_data(tape_wr_data), .wr_ready(tape_wr_ready));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  function automatic ict_cmd_t mk(input logic [14:0] cnt, input logic nt, input logic [14:0] ad);
    mk = '{3'h0, cnt, 1'b0, nt, 1'b0, ad};
  endfunction : mk
  task automatic sel(input logic w, input logic [3:0] ch, input logic [4:0] md, input logic [3:0] un);
    @(posedge clk);
    #1 cpu_sel_valid = 1'b1;
    cpu_sel_write = w;
    cpu_sel_addr = '{2'h0, ch, md, un};
    @(posedge clk);
    #1 cpu_sel_valid = 1'b0;
  endtask : sel
  task automatic start(input logic [14:0] ad);
    @(posedge clk);
    #1 cpu_start_valid = 1'b1;
    cpu_start_addr = ad;
    @(posedge clk);
    #1 cpu_start_valid = 1'b0;
  endtask : start
  task automatic wait_idle();
    for (int i = 0; i < 400 && chan_busy !== 1'b0; i++)
      @(posedge clk) #1;
    check("busy end", 36'h0, 36'(chan_busy));
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////
  // Processor waits whenever the channel wants storage
  always @(negedge clk)
    if (!rst && mem_req && cpu_mem_req) check("cpu yields", 36'h1, 36'(cpu_stall && !cpu_mem_gnt));
  always @(posedge clk)
  begin
    cyc++;
    if (tape_disc) ndisc++;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic t_read();
    i_far.mem[4] = mk(15'h0003, 1'b0, 15'h000a);
    b = i_far.nrd;
    cpu_mem_req = 1'b1;
    sel(1'b0, 4'h1, UNIT_BCD, 4'h1);
    check("sel read", 36'h1, 36'(tape_sel));
    start(15'h0004);
    wait_idle();
    cpu_mem_req = 1'b0;
    for (int k = 0; k < 3; k++)
      check("stored word", {4'h9, 32'h5a5a0000 + 32'(b + k)}, i_far.mem[10 + k]);
    check("count", 36'h0, 36'(stat_word.count));
    check("addr", 36'h00d, 36'(stat_word.addr));
    check("loc", 36'h005, 36'(stat_loc));
    check("disc", 36'h1, 36'(ndisc));
    $display("test read done");
  endtask : t_read
  task automatic t_skip();
    // Transfer command first, so the chain reloads the command pointer
    i_far.mem[6] = {OP_TRANSFER, 18'h00000, 15'h000e};
    i_far.mem[14] = mk(15'h0002, 1'b1, 15'h0014);
    i_far.mem[20] = 36'h123456789;
    sel(1'b0, 4'h1, UNIT_BCD, 4'h2);
    start(15'h0006);
    wait_idle();
    check("skipped", 36'h123456789, i_far.mem[20]);
    check("loc", 36'h00f, 36'(stat_loc));
    check("op", 36'h1, 36'(stat_word.nontx));
    check("addr", 36'h016, 36'(stat_word.addr));
    $display("test skip done");
  endtask : t_skip
  task automatic t_write_wrap();
    i_far.mem[8] = mk(15'h0002, 1'b0, 15'h7fff);
    i_far.mem[31] = 36'h0aaaabbbb;
    i_far.mem[0] = 36'h0ccccdddd;
    b = i_far.nwr;
    sel(1'b1, 4'h1, UNIT_BIN, 4'h3);
    check("sel mode", 36'h7, 36'({tape_sel_write, tape_sel_binary, tape_sel_unit == 4'h3}));
    start(15'h0008);
    wait_idle();
    check("words out", 36'(b + 2), 36'(i_far.nwr));
    check("wrapped word", 36'h0ccccdddd, i_far.last_wr);
    check("addr", 36'h001, 36'(stat_word.addr));
    $display("test write done");
  endtask : t_write_wrap
  task automatic t_eof();
    i_far.mem[12] = mk(15'h0005, 1'b0, 15'h0018);
    i_far.mem[26] = 36'h0fedcba98;
    b = ndisc;
    ext_chan_req = 8'h06;
    cpu_mem_req = 1'b1;
    sel(1'b0, 4'h1, UNIT_BCD, 4'h4);
    check("other gnt", 36'h002, 36'(chan_gnt));
    check("cpu held", 36'h2, 36'({cpu_stall, cpu_mem_gnt}));
    start(15'h000c);
    @(negedge clk);
    check("own gnt", 36'h001, 36'(chan_gnt));
    @(posedge clk) #1 ext_chan_req = 8'h00;
    for (int i = 0; i < 100 && stat_word.count !== 15'h0003; i++)
      @(posedge clk) #1;
    tape_eof = 1'b1;
    @(posedge clk) #1 tape_eof = 1'b0;
    cpu_mem_req = 1'b0;
    check("eof stop", 36'h0, 36'(chan_busy));
    check("eof count", 36'h003, 36'(stat_word.count));
    check("eof addr", 36'h01a, 36'(stat_word.addr));
    check("eof loc", 36'h00d, 36'(stat_loc));
    check("eof no store", 36'h0fedcba98, i_far.mem[26]);
    check("eof disc", 36'(b + 1), 36'(ndisc));
    $display("test eof done");
  endtask : t_eof
  task automatic t_late();
    sel(1'b0, 4'h2, UNIT_BCD, 4'h1);
    sel(1'b0, 4'h1, UNIT_BCD, 4'hb);
    check("bad sel", 36'h0, 36'(tape_sel));
    sel(1'b0, 4'h1, UNIT_BCD, 4'ha);
    check("unit ten", 36'h1, 36'(tape_sel));
    cpu_start_opcode = 12'h002;
    start(15'h0004);
    check("foreign start", 36'h2, 36'({io_check, tape_sel, chan_busy}));
    cpu_start_opcode = 12'h001;
    repeat (WIN_CYC + 5) @(posedge clk);
    #1 check("late drop", 36'h0, 36'(tape_sel));
    start(15'h0004);
    check("io check", 36'h2, 36'({io_check, chan_busy}));
    @(posedge clk);
    #1 cpu_io_test = 1'b1;
    @(posedge clk);
    #1 cpu_io_test = 1'b0;
    check("io clear", 36'h0, 36'(io_check));
    $display("test late done");
  endtask : t_late
  initial
  begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    t_read();
    t_skip();
    t_write_wrap();
    t_eof();
    t_late();
    conclude();
  end
endmodule : test_io_channel_transfer_engine
`default_nettype wire
